// ---- logic/cst_pkg.sv ----
package cst_pkg;

  // events and levels from the execution datapath
  typedef struct packed {
    logic       acc_a_ovf;
    logic       acc_b_ovf;
    logic       acc_a_sat;
    logic       acc_b_sat;
    logic       acc_a_cat;
    logic       acc_b_cat;
    logic       loop_active;
    logic       alu_valid;
    logic       alu_byte;
    logic       carry4;
    logic       carry8;
    logic       bad_shift;
    logic       div_zero;
    logic       addr_err;
    logic       pri_load;
    logic [2:0] pri_value;
  } cst_dp_t;

  // requests and levels toward the interrupt controller
  typedef struct packed {
    logic       ovf_trap;
    logic       cat_trap;
    logic       math_trap;
    logic       addr_trap;
    logic [3:0] cpu_priority_level;
    logic       user_irq_disable;
    logic       nesting_disable;
  } cst_trap_t;

  // whole state of the block
  typedef struct packed {
    logic [15:0] sr;
    logic [15:0] tc;
    logic        pri3;
    logic [4:0]  irq_st;
    logic [4:0]  irq_msk;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic        ovf_trap;
    logic        cat_trap;
    logic        math_trap;
    logic        addr_trap;
  } cst_state_t;

endpackage : cst_pkg

// ---- logic/cst_regs.svh ----
`ifndef CST_REGS_SVH
`define CST_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CST_OFF_STATUS   8'h00
`define CST_OFF_TRAP     8'h04
`define CST_OFF_CORE     8'h08
`define CST_OFF_IRQ_ST   8'h0C
`define CST_OFF_IRQ_MSK  8'h10

// ----------------------------------------
// core status word fields
// ----------------------------------------
`define CST_SR_OA        15
`define CST_SR_OB        14
`define CST_SR_SA        13
`define CST_SR_SB        12
`define CST_SR_OAB       11
`define CST_SR_SAB       10
`define CST_SR_DA        9
`define CST_SR_DC        8
`define CST_SR_PRI_HI    7
`define CST_SR_PRI_LO    5
`define CST_SR_MASK      16'hFFE0

// ----------------------------------------
// trap control word fields
// ----------------------------------------
`define CST_TC_NST       15
`define CST_TC_OVA       14
`define CST_TC_OVB       13
`define CST_TC_COVA      12
`define CST_TC_COVB      11
`define CST_TC_ACC_A_OVERFLOW_TRAP_ENABLE     10
`define CST_TC_ACC_B_OVERFLOW_TRAP_ENABLE     9
`define CST_TC_CATASTROPHIC_TRAP_ENABLE     8
`define CST_TC_SFT       7
`define CST_TC_DIV0      6
`define CST_TC_MATH      4
`define CST_TC_ADDR      3
`define CST_TC_MASK      16'hFFD8

// ----------------------------------------
// core control, interrupt bits, resets
// ----------------------------------------
`define CST_CC_PRI3      3
`define CST_IRQ_OVF      0
`define CST_IRQ_CAT      1
`define CST_IRQ_MATH     2
`define CST_IRQ_ADDR     3
`define CST_IRQ_SAT      4
`define CST_RST_REG16    16'h0000
`define CST_RST_IRQ      5'h00
`define CST_RST_WORD     32'h0000_0000

`endif

// ---- logic/cst_status_trap.sv ----
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "cst_regs.svh"

// Behaviour
// - per-accumulator overflow bits follow the datapath, read only
// - per-accumulator saturation flags are sticky; software only clears them
// - combined overflow bit is the OR of both overflow bits
// - combined sticky saturation bit; clearing it clears both per-accumulator flags
// - loop-active bit shows a hardware loop in progress
// - half carry taken from bit 4 (byte) or bit 8 (word) carry
// - nesting disable blocks nesting and freezes the priority field for software
// - overflow trap flags per accumulator record an overflow trap
// - catastrophic trap flags per accumulator record a catastrophic trap
// - per-accumulator overflow trap enables gate the overflow trap
// - one catastrophic enable gates catastrophic traps of both accumulators
// - bad shift flag records an invalid accumulator shift math error
// - address error flag records an address error trap
// - unimplemented trap bits read zero; all status bits reset to zero
module cst_status_trap (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire cst_pkg::cst_dp_t     dp,
  output cst_pkg::cst_trap_t        trap,
  output logic                      irq
);
  import cst_pkg::*;

  // ----------------------------------------
  // address decode
  // ----------------------------------------

  // one-hot register select, shared by the
  // read path and the write data phase
  function automatic logic [4:0] cst_dec(
    input logic [7:0] a
  );
    logic [4:0] sel;
    sel = 5'h00;
    // unmapped offsets select nothing, so
    // writes there fall on the floor
    unique case (a)
      `CST_OFF_STATUS:  sel = 5'h01;
      `CST_OFF_TRAP:    sel = 5'h02;
      `CST_OFF_CORE:    sel = 5'h04;
      `CST_OFF_IRQ_ST:  sel = 5'h08;
      `CST_OFF_IRQ_MSK: sel = 5'h10;
      default:          sel = 5'h00;
    endcase
    return sel;
  endfunction : cst_dec

  // ----------------------------------------
  // state
  // ----------------------------------------

  cst_state_t s;
  cst_state_t next_s;

  // helpers of the next-state process; all
  // are given a value on every pass
  logic        take;
  logic [4:0]  wsel;
  logic [4:0]  rsel;
  logic [15:0] w;
  logic        ova_rise;
  logic        ovb_rise;
  logic        ova_trap;
  logic        ovb_trap;
  logic        cova_trap;
  logic        covb_trap;
  logic        math_evt;
  logic [4:0]  irq_evt;
  logic [31:0] rword;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------

  always_comb begin
    next_s = s;
    // trap requests are single-cycle pulses
    next_s.ovf_trap  = 1'h0;
    next_s.cat_trap  = 1'h0;
    next_s.math_trap = 1'h0;
    next_s.addr_trap = 1'h0;

    // bus address phase; only word access
    // is meant, other sizes act as a word
    take = hsel & hready & htrans[1];
    next_s.wr_pend = take & hwrite;
    if (take) begin
      next_s.wr_addr = haddr[7:0];
    end

    // write data phase
    wsel = cst_dec(s.wr_addr) & {5{s.wr_pend}};
    w    = hwdata[15:0];

    // ----------------------------------------
    // software writes, data phase
    // ----------------------------------------

    // status word: sticky bits clear on a
    // written zero, writing one does nothing
    if (wsel[0]) begin
      if (!w[`CST_SR_SA]) begin
        next_s.sr[`CST_SR_SA] = 1'h0;
      end
      if (!w[`CST_SR_SB]) begin
        next_s.sr[`CST_SR_SB] = 1'h0;
      end
      // combined clear takes both flags
      if (!w[`CST_SR_SAB]) begin
        next_s.sr[`CST_SR_SA] = 1'h0;
        next_s.sr[`CST_SR_SB] = 1'h0;
      end
      next_s.sr[`CST_SR_DC] = w[`CST_SR_DC];
      // priority frozen while nesting is off;
      // a frozen write is dropped silently,
      // no bus error is raised
      if (!s.tc[`CST_TC_NST]) begin
        next_s.sr[`CST_SR_PRI_HI:`CST_SR_PRI_LO] =
          w[`CST_SR_PRI_HI:`CST_SR_PRI_LO];
      end
    end

    // trap control word; holes stay zero
    if (wsel[1]) begin
      next_s.tc = w & `CST_TC_MASK;
    end

    // core control: fourth priority bit
    if (wsel[2]) begin
      next_s.pri3 = w[`CST_CC_PRI3];
    end

    // interrupt status: write one to clear
    if (wsel[3]) begin
      next_s.irq_st = s.irq_st & ~w[4:0];
    end

    // interrupt mask
    if (wsel[4]) begin
      next_s.irq_msk = w[4:0];
    end

    // ----------------------------------------
    // hardware updates
    // ----------------------------------------

    // hardware updates come after software
    // writes so a same-cycle event wins

    // overflow levels from the datapath
    next_s.sr[`CST_SR_OA] = dp.acc_a_ovf;
    next_s.sr[`CST_SR_OB] = dp.acc_b_ovf;

    // saturation is sticky until cleared
    if (dp.acc_a_sat) begin
      next_s.sr[`CST_SR_SA] = 1'h1;
    end
    if (dp.acc_b_sat) begin
      next_s.sr[`CST_SR_SB] = 1'h1;
    end

    // combined bits track their sources
    next_s.sr[`CST_SR_OAB] =
      next_s.sr[`CST_SR_OA] |
      next_s.sr[`CST_SR_OB];
    next_s.sr[`CST_SR_SAB] =
      next_s.sr[`CST_SR_SA] |
      next_s.sr[`CST_SR_SB];

    // hardware loop in progress
    next_s.sr[`CST_SR_DA] = dp.loop_active;

    // half carry from the right bit; a valid
    // alu result or a status write moves it,
    // otherwise the last value holds
    if (dp.alu_valid) begin
      next_s.sr[`CST_SR_DC] =
        dp.alu_byte ? dp.carry4 : dp.carry8;
    end

    // interrupt controller loads priority
    // on entry and return, nesting or not
    if (dp.pri_load) begin
      next_s.sr[`CST_SR_PRI_HI:`CST_SR_PRI_LO] =
        dp.pri_value;
    end

    // ----------------------------------------
    // trap causes
    // ----------------------------------------

    // an overflow is the rising edge of
    // the level, so a held overflow traps
    // only once
    ova_rise = dp.acc_a_ovf & ~s.sr[`CST_SR_OA];
    ovb_rise = dp.acc_b_ovf & ~s.sr[`CST_SR_OB];
    ova_trap = ova_rise & s.tc[`CST_TC_ACC_A_OVERFLOW_TRAP_ENABLE];
    ovb_trap = ovb_rise & s.tc[`CST_TC_ACC_B_OVERFLOW_TRAP_ENABLE];

    // one enable serves both accumulators
    cova_trap = dp.acc_a_cat &
                s.tc[`CST_TC_CATASTROPHIC_TRAP_ENABLE];
    covb_trap = dp.acc_b_cat &
                s.tc[`CST_TC_CATASTROPHIC_TRAP_ENABLE];

    // trap cause flags; set beats clear
    if (ova_trap) begin
      next_s.tc[`CST_TC_OVA] = 1'h1;
    end
    if (ovb_trap) begin
      next_s.tc[`CST_TC_OVB] = 1'h1;
    end
    if (cova_trap) begin
      next_s.tc[`CST_TC_COVA] = 1'h1;
    end
    if (covb_trap) begin
      next_s.tc[`CST_TC_COVB] = 1'h1;
    end

    // math error causes
    if (dp.bad_shift) begin
      next_s.tc[`CST_TC_SFT] = 1'h1;
    end
    if (dp.div_zero) begin
      next_s.tc[`CST_TC_DIV0] = 1'h1;
    end

    // every trap cause but the address error
    // counts as a math error, accumulator traps included
    math_evt = dp.bad_shift | dp.div_zero |
               ova_trap | ovb_trap |
               cova_trap | covb_trap;
    if (math_evt) begin
      next_s.tc[`CST_TC_MATH] = 1'h1;
    end

    // address error
    if (dp.addr_err) begin
      next_s.tc[`CST_TC_ADDR] = 1'h1;
    end

    // trap request pulses
    next_s.ovf_trap  = ova_trap | ovb_trap;
    next_s.cat_trap  = cova_trap | covb_trap;
    next_s.math_trap = math_evt;
    next_s.addr_trap = dp.addr_err;

    // events into the interrupt status
    irq_evt = 5'h00;
    irq_evt[`CST_IRQ_OVF]  = ova_trap | ovb_trap;
    irq_evt[`CST_IRQ_CAT]  = cova_trap | covb_trap;
    irq_evt[`CST_IRQ_MATH] = math_evt;
    irq_evt[`CST_IRQ_ADDR] = dp.addr_err;
    irq_evt[`CST_IRQ_SAT]  = dp.acc_a_sat |
                             dp.acc_b_sat;
    next_s.irq_st = next_s.irq_st | irq_evt;

    // ----------------------------------------
    // read data
    // ----------------------------------------

    // read path: data is built from the
    // updated values, so a read right after
    // a write sees the written data
    rsel  = cst_dec(haddr[7:0]);
    rword = `CST_RST_WORD;
    unique case (1'h1)
      rsel[0]: begin
        rword[15:0] = next_s.sr & `CST_SR_MASK;
      end
      rsel[1]: begin
        rword[15:0] = next_s.tc & `CST_TC_MASK;
      end
      rsel[2]: begin
        rword[`CST_CC_PRI3] = next_s.pri3;
      end
      rsel[3]: begin
        rword[4:0] = next_s.irq_st;
      end
      rsel[4]: begin
        rword[4:0] = next_s.irq_msk;
      end
      default: begin
        // unmapped reads answer zero
        rword = `CST_RST_WORD;
      end
    endcase
    if (take & ~hwrite) begin
      next_s.hrdata = rword;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------

  // every implemented bit starts at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s.sr        <= `CST_RST_REG16;
      s.tc        <= `CST_RST_REG16;
      s.pri3      <= 1'h0;
      s.irq_st    <= `CST_RST_IRQ;
      s.irq_msk   <= `CST_RST_IRQ;
      // no bus write is pending out of reset
      s.wr_pend   <= 1'h0;
      s.wr_addr   <= 8'h00;
      s.hrdata    <= `CST_RST_WORD;
      s.ovf_trap  <= 1'h0;
      s.cat_trap  <= 1'h0;
      s.math_trap <= 1'h0;
      s.addr_trap <= 1'h0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------

  // no wait states, always OKAY; every
  // register answers in one cycle, so a
  // data phase ends at the next edge
  assign hreadyout = 1'h1;
  assign hresp     = 1'h0;
  assign hrdata    = s.hrdata;

  // trap requests toward the controller;
  // each pulse lasts one cycle, so the
  // controller must take it on that edge
  assign trap.ovf_trap  = s.ovf_trap;
  assign trap.cat_trap  = s.cat_trap;
  assign trap.math_trap = s.math_trap;
  assign trap.addr_trap = s.addr_trap;

  // full level is the fourth bit on top
  // of the three-bit field
  assign trap.cpu_priority_level = {
    s.pri3,
    s.sr[`CST_SR_PRI_HI:`CST_SR_PRI_LO]
  };

  // top priority bit shuts out user irqs
  assign trap.user_irq_disable = s.pri3;

  // controller must not nest while set
  assign trap.nesting_disable =
    s.tc[`CST_TC_NST];

  // level interrupt from unmasked status;
  // it drops only when software clears
  // or masks the status bit behind it
  assign irq = |(s.irq_st & s.irq_msk);

endmodule : cst_status_trap

// ---- testbench/cst_dp_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// datapath stand-in feeding events and levels
// ----------------------------------------
module cst_dp_model (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire cst_pkg::cst_dp_t req,
  output cst_pkg::cst_dp_t      dp
);
  import cst_pkg::*;
  // registered like a real pipeline; unqualified fields churn so stale values never help
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp <= '0;
    end else begin
      dp <= req;
      if (!req.alu_valid) begin
        {dp.alu_byte, dp.carry4, dp.carry8} <= ~{dp.alu_byte, dp.carry4, dp.carry8};
      end
      if (!req.pri_load) begin
        dp.pri_value <= ~dp.pri_value;
      end
    end
  end
endmodule : cst_dp_model

// ---- testbench/cst_status_trap_monitor.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port checks for the status and trap block
// ----------------------------------------
module cst_status_trap_monitor (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic [31:0]        hrdata,
  input wire cst_pkg::cst_dp_t   dp,
  input wire cst_pkg::cst_trap_t trap
);
  import cst_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // a lone address fault pulse and the single trap pulse it must produce
  sequence s_addr_cause;
    dp.addr_err ##1 !dp.addr_err;
  endsequence
  sequence s_addr_answer;
    trap.addr_trap ##1 !trap.addr_trap;
  endsequence

  property p_ovf;
    trap.ovf_trap |-> $past(dp.acc_a_ovf || dp.acc_b_ovf);
  endproperty
  property p_cat;
    trap.cat_trap |-> $past(dp.acc_a_cat || dp.acc_b_cat);
  endproperty
  property p_math;
    (dp.bad_shift || dp.div_zero) |=> trap.math_trap;
  endproperty
  property p_addr;
    s_addr_cause |-> s_addr_answer;
  endproperty
  property p_pri;
    dp.pri_load |=> trap.cpu_priority_level[2:0] == $past(dp.pri_value);
  endproperty
  property p_uid;
    trap.user_irq_disable == trap.cpu_priority_level[3];
  endproperty
  // only the datapath may move the field while nesting is off
  property p_frz;
    trap.nesting_disable && !$past(dp.pri_load) |-> $stable(trap.cpu_priority_level[2:0]);
  endproperty
  property p_rst;
    $rose(hresetn) |-> hrdata == 32'h0000_0000 && trap == '0;
  endproperty

  a_ovf: assert property (p_ovf) else $error("overflow trap without cause");
  a_cat: assert property (p_cat) else $error("catastrophic trap without cause");
  a_math: assert property (p_math) else $error("math fault gave no trap");
  a_addr: assert property (p_addr) else $error("address fault pulse wrong");
  a_pri: assert property (p_pri) else $error("priority load lost");
  a_uid: assert property (p_uid) else $error("user disable not top level bit");
  a_frz: assert property (p_frz) else $error("priority moved while frozen");
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule : cst_status_trap_monitor

bind cst_status_trap cst_status_trap_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .dp(dp), .trap(trap)
);

// ---- testbench/cst_status_trap_test.sv ----
`timescale 1ns/1ps
`include "cst_regs.svh"
// ----------------------------------------
// bench for the status and trap block
// ----------------------------------------
module cst_status_trap_test;
  import cst_pkg::*;
  typedef struct {string n; logic [31:0] v;} cst_note_t;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq, rph;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, seed, r;
  cst_dp_t     req, dp;
  cst_trap_t   trap;
  cst_note_t   q[$];
  cst_note_t   nt;
  int          n_mismatch, samples_checked;
  int          n_pulse [4];

  cst_status_trap cst_status_trap_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .dp(dp),
    .trap(trap), .irq(irq));
  cst_dp_model cst_dp_model_inst (.hclk(hclk), .hresetn(hresetn), .req(req), .dp(dp));

  // 200 MHz clock
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // single word transfer; a read leaves its expectation for the watcher
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] v, input string n);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, v};
    if (!w) q.push_back('{n, {16'h0000, v}});
    rph <= !w;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    rph <= 1'h0;
  endtask : bus

  // one-cycle datapath pulse, then let it settle into the registers
  task automatic ev(input cst_dp_t p);
    req <= req | p;
    @(posedge hclk);
    req <= req & ~p;
    repeat (3) @(posedge hclk);
  endtask : ev

  task automatic lv(input cst_dp_t p, input logic on);
    req <= on ? req | p : req & ~p;
    repeat (3) @(posedge hclk);
  endtask : lv

  // enable, event, then the recorded trap word
  task automatic tr(input cst_dp_t p, input logic [15:0] en, input logic [15:0] x);
    bus(1'h1, `CST_OFF_TRAP, en, "");
    ev(p);
    bus(1'h0, `CST_OFF_TRAP, x, "trap");
  endtask : tr

  // watcher: each read result meets the oldest note
  always @(posedge hclk) begin
    if (rph === 1'h1) begin
      nt = q.pop_front();
      chk(nt.n, hrdata, nt.v);
      chk("hresp", {31'h0, hresp}, 32'h0);
    end
  end

  // trap pulses tallied per kind; a pulse that
  // stretched or never came shows in the totals
  always @(posedge hclk) begin
    n_pulse[0] += trap.ovf_trap;
    n_pulse[1] += trap.cat_trap;
    n_pulse[2] += trap.math_trap;
    n_pulse[3] += trap.addr_trap;
  end

  // watchdog, far beyond the expected run
  initial begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    {hresetn, hsel, hwrite, rph, htrans} = '0;
    {haddr, hwdata, req} = '0;
    hsize = 3'h2;
    seed = 32'h9232;
    {n_mismatch, samples_checked} = '0;
    n_pulse = '{default: 0};
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, `CST_OFF_STATUS, 16'h0000, "status");
    bus(1'h0, 8'h14, 16'h0000, "unmapped");
    bus(1'h1, `CST_OFF_TRAP, 16'hFFFF, "");
    bus(1'h0, `CST_OFF_TRAP, 16'hFFD8, "trap");
    bus(1'h1, `CST_OFF_TRAP, 16'h0400, "");
    lv(cst_dp_t'{acc_a_ovf: 1'h1, default: '0}, 1'h1);
    bus(1'h0, `CST_OFF_STATUS, 16'h8800, "status");
    bus(1'h0, `CST_OFF_TRAP, 16'h4410, "trap");
    bus(1'h0, `CST_OFF_IRQ_ST, 16'h0005, "irq_st");
    bus(1'h1, `CST_OFF_IRQ_MSK, 16'h0001, "");
    @(posedge hclk) chk("irq", {31'h0, irq}, 32'h1);
    lv(cst_dp_t'{acc_a_ovf: 1'h1, default: '0}, 1'h0);
    bus(1'h1, `CST_OFF_IRQ_ST, 16'h0005, "");
    @(posedge hclk) chk("irq", {31'h0, irq}, 32'h0);
    bus(1'h1, `CST_OFF_TRAP, 16'h0000, "");
    lv(cst_dp_t'{acc_b_ovf: 1'h1, default: '0}, 1'h1);
    bus(1'h0, `CST_OFF_STATUS, 16'h4800, "status");
    bus(1'h0, `CST_OFF_TRAP, 16'h0000, "trap");
    lv(cst_dp_t'{acc_b_ovf: 1'h1, loop_active: 1'h1, default: '0}, 1'h0);
    $display("overflow test done");
    ev(cst_dp_t'{acc_a_sat: 1'h1, acc_b_sat: 1'h1, default: '0});
    bus(1'h1, `CST_OFF_STATUS, 16'hFFFF, "");
    bus(1'h0, `CST_OFF_STATUS, 16'h35E0, "status");
    bus(1'h1, `CST_OFF_STATUS, 16'h0000, "");
    bus(1'h0, `CST_OFF_STATUS, 16'h0000, "status");
    lv(cst_dp_t'{loop_active: 1'h1, default: '0}, 1'h1);
    bus(1'h0, `CST_OFF_STATUS, 16'h0200, "status");
    lv(cst_dp_t'{loop_active: 1'h1, default: '0}, 1'h0);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      ev(cst_dp_t'{alu_valid: 1'h1, alu_byte: r[2], carry4: r[1], carry8: r[0], default: '0});
      bus(1'h0, `CST_OFF_STATUS, {7'h00, r[2] ? r[1] : r[0], 8'h00}, "status");
    end
    $display("status test done");
    tr(cst_dp_t'{acc_a_cat: 1'h1, default: '0}, 16'h0100, 16'h1110);
    tr(cst_dp_t'{acc_b_cat: 1'h1, default: '0}, 16'h0100, 16'h0910);
    tr(cst_dp_t'{acc_a_cat: 1'h1, default: '0}, 16'h0000, 16'h0000);
    tr(cst_dp_t'{bad_shift: 1'h1, default: '0}, 16'h0000, 16'h0090);
    tr(cst_dp_t'{div_zero: 1'h1, default: '0}, 16'h0000, 16'h0050);
    tr(cst_dp_t'{addr_err: 1'h1, default: '0}, 16'h0000, 16'h0008);
    $display("trap test done");
    r = rnd();
    ev(cst_dp_t'{pri_load: 1'h1, pri_value: r[2:0], default: '0});
    bus(1'h1, `CST_OFF_CORE, 16'h0008, "");
    @(posedge hclk) chk("level", {28'h0, trap.cpu_priority_level}, {28'h0, 1'h1, r[2:0]});
    chk("user_off", {31'h0, trap.user_irq_disable}, 32'h1);
    bus(1'h1, `CST_OFF_TRAP, 16'h8000, "");
    bus(1'h1, `CST_OFF_STATUS, 16'h0000, "");
    bus(1'h0, `CST_OFF_STATUS, {8'h00, r[2:0], 5'h00}, "status");
    @(posedge hclk) chk("nesting", {31'h0, trap.nesting_disable}, 32'h1);
    $display("priority test done");
    chk("ovf_pulses", n_pulse[0], 32'h1);
    chk("cat_pulses", n_pulse[1], 32'h2);
    chk("math_pulses", n_pulse[2], 32'h5);
    chk("addr_pulses", n_pulse[3], 32'h1);
    finish_test();
  end
endmodule : cst_status_trap_test
